// >>> sim/pin_partner.sv
/*
 * Far-side model: the external count, capture and neighbour-timer pins
 * that face the dual timer unit. Assumes the bench requests one pin change
 * at a time, on a rising edge of the shared system clock.
 */
`timescale 1ns/1ps
module pin_partner
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [4:0] flip,
   output logic      [4:0] pins
);
   // ==========================================================
   // pin levels
   // one request bit flips one pin, so each request is one clean edge;
   // the pins are push-pull and never released, so no float modelling
   always_ff @(posedge clk)
   begin
      if (rst)
         pins <= 5'h00;
      else
         pins <= pins ^ flip;
   end
endmodule : pin_partner

// >>> sim/tb.sv
/*
 * Self-checking bench for the dual timer unit: register port, prescaler,
 * chained timers, toggle latch, reload, capture and interrupt. Assumes the
 * pin partner model for the external pins and one 25 MHz clock.
 */
`timescale 1ns/1ps
module tb;
   import dtcr_pkg::*;
   typedef struct {
      logic [DW-1:0] ctl;
      logic [DW-1:0] val;
      int            b;
      logic [DW-1:0] cap;
      logic [DW-1:0] aux;
   } cap_row_t;
   logic          mclk  = 1'b0;
   logic          rst   = 1'b1;
   logic          ce    = 1'b1;
   logic [AW-1:0] addr  = '0;
   logic [DW-1:0] wdata = '0;
   logic          wr    = 1'b0;
   logic          rd    = 1'b0;
   logic          cdir  = 1'b0;
   logic          adir  = 1'b0;
   logic [4:0]    flip  = '0;
   logic [4:0]    pins;
   logic [DW-1:0] rdata;
   logic [DW-1:0] v;
   logic [DW-1:0] a0;
   logic [DW-1:0] a1;
   logic          tpin;
   logic          cmpo;
   logic          irq;
   int            n_mismatch  = 0;
   int            check_count = 0;
   int            cmp_n       = 0;
   int            i;
   // ctl, aux preset, pin to flip, capture expected, aux expected
   cap_row_t      rows [7] = '{
      '{16'h0B06, 16'h0055, 2, 16'h0055, 16'h0000},
      '{16'h0B06, 16'h0077, 2, 16'h0055, 16'h0077},
      '{16'h0506, 16'h0044, 2, 16'h0055, 16'h0044},
      '{16'h0506, 16'h0044, 2, 16'h0044, 16'h0044},
      '{16'h1006, 16'h0022, 3, 16'h0022, 16'h0022},
      '{16'h2006, 16'h0033, 4, 16'h0033, 16'h0033},
      '{16'h0006, 16'h0011, 3, 16'h0033, 16'h0011}};

   always #20 mclk = ~mclk;

   always @(posedge mclk)
      if (cmpo === 1'b1)
         cmp_n <= cmp_n + 1;

   pin_partner u_pin_partner (.clk(mclk), .rst(rst), .flip(flip),
                              .pins(pins));

   dual_timer_capture_reload u_dual_timer_capture_reload (
      .MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .CORE_COUNT_PIN(pins[0]),
      .AUX_COUNT_PIN(pins[1]), .CORE_DIRECTION_PIN(cdir),
      .AUX_DIRECTION_PIN(adir), .CAPTURE_INPUT_PIN(pins[2]),
      .NEIGHBOR_COUNT_INPUT(pins[3]), .NEIGHBOR_DIRECTION_INPUT(pins[4]),
      .TOGGLE_LATCH_PIN(tpin), .COMPARE_CLK_OUT(cmpo), .IRQ(irq));

   // ==========================================================
   // bus and check tasks
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask : rd_reg

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk

   // one edge on one far-side pin, then time for it to land
   task automatic tog(input int b);
      @(posedge mclk);
      flip <= 5'(1 << b);
      @(posedge mclk);
      flip <= '0;
      repeat (3) @(posedge mclk);
   endtask : tog

   task automatic note(input string s);
      $display("test %s done", s);
   endtask : note

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // watchdog: whole run needs under 4000 cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      wrap_up;
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         rd_reg(3'(i), v);
         chk(v, REG_RST);
      end
      chk(16'({tpin, cmpo, irq}), 16'h0000);
      wr_reg(REG_CORE_CTL, 16'h03F8);
      rd_reg(REG_CORE_CTL, v);
      chk(v, 16'h03F8);
      wr_reg(REG_AUX_CTL, 16'h3FF8);
      rd_reg(REG_AUX_CTL, v);
      chk(v, 16'h3FF8);
      wr_reg(REG_MASK, 16'hFFFF);
      rd_reg(REG_MASK, v);
      chk(v, 16'h000F);
      wr_reg(3'h7, 16'hFFFF);
      rd_reg(3'h7, v);
      chk(v, 16'h0000);
      // a write with the clock enable low must be lost
      @(posedge mclk);
      ce <= 1'b0;
      wr_reg(REG_CAP_RLD, 16'h1234);
      @(posedge mclk);
      ce <= 1'b1;
      rd_reg(REG_CAP_RLD, v);
      chk(v, 16'h0000);
      wr_reg(REG_AUX_CTL, 16'h0000);
      note("registers");

      for (i = 0; i < 8; i += 3)
      begin
         wr_reg(REG_CORE_CTL, 16'h0009 | 16'(i << 5));
         rd_reg(REG_CORE_CNT, a0);
         repeat ((8 << i) - 2) @(posedge mclk);
         rd_reg(REG_CORE_CNT, a1);
         chk(a1 - a0, 16'h0004);
      end
      note("prescaler");

      wr_reg(REG_CORE_CTL, 16'h0000);
      wr_reg(REG_CAP_RLD, 16'h1000);
      wr_reg(REG_CORE_CNT, 16'hFFFF);
      wr_reg(REG_AUX_CNT, 16'h0000);
      wr_reg(REG_AUX_CTL, 16'h000D);
      wr_reg(REG_MASK, 16'h0001);
      wr_reg(REG_STATUS, 16'h000F);
      wr_reg(REG_CORE_CTL, 16'h030B);
      tog(0);
      tog(0);
      chk(16'(tpin), 16'h0001);
      rd_reg(REG_CORE_CNT, v);
      chk(v, 16'h1000);
      rd_reg(REG_STATUS, v);
      chk(v, 16'h0001);
      chk(16'(irq), 16'h0001);
      wr_reg(REG_STATUS, 16'h0001);
      repeat (2) @(posedge mclk);
      chk(16'(irq), 16'h0000);
      wr_reg(REG_CORE_CNT, 16'h0000);
      @(posedge mclk);
      cdir <= 1'b1;
      wr_reg(REG_CORE_CTL, 16'h031B);
      tog(0);
      tog(0);
      chk(16'(tpin), 16'h0000);
      rd_reg(REG_CORE_CNT, v);
      chk(v, 16'h1000);
      rd_reg(REG_STATUS, v);
      chk(v, 16'h0002);
      rd_reg(REG_AUX_CNT, v);
      chk(v, 16'h0002);
      chk(16'(cmp_n), 16'h0002);
      note("chain");

      wr_reg(REG_CORE_CTL, 16'h0000);
      wr_reg(REG_STATUS, 16'h000F);
      wr_reg(REG_AUX_CNT, 16'hFFFF);
      wr_reg(REG_AUX_CTL, 16'h000B);
      tog(1);
      tog(1);
      rd_reg(REG_AUX_CNT, v);
      chk(v, 16'h0000);
      rd_reg(REG_STATUS, v);
      chk(v, 16'h0004);
      wr_reg(REG_STATUS, 16'h000F);
      @(posedge mclk);
      adir <= 1'b1;
      wr_reg(REG_AUX_CTL, 16'h001B);
      tog(1);
      tog(1);
      rd_reg(REG_AUX_CNT, v);
      chk(v, 16'hFFFF);
      rd_reg(REG_STATUS, v);
      chk(v, 16'h0004);
      wr_reg(REG_STATUS, 16'h000F);
      note("aux");

      for (i = 0; i < 7; i++)
      begin
         wr_reg(REG_AUX_CTL, rows[i].ctl);
         wr_reg(REG_AUX_CNT, rows[i].val);
         tog(rows[i].b);
         rd_reg(REG_CAP_RLD, v);
         chk(v, rows[i].cap);
         rd_reg(REG_AUX_CNT, v);
         chk(v, rows[i].aux);
      end
      rd_reg(REG_STATUS, v);
      chk(v, 16'h0008);
      note("capture");

      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(REG_CAP_RLD, v);
      chk(v, REG_RST);
      rd_reg(REG_AUX_CTL, v);
      chk(v, REG_RST);
      note("reset");
      wrap_up;
   end
endmodule : tb

// >>> src/dtcr_pkg.sv
/*
 * Constants, register map, field layout and shared helpers of the dual
 * timer with capture/reload. Assumes a single clock and a plain register
 * port driven by a master that never waits.
 */
// Function
// - prescaled count clock ticks at most once every two system clocks
// - two independent timers, core and auxiliary, plus one capture/reload
// - each timer counts prescaled system clock or an external pin edge
// - direction set by software, inverted at run time by a pin level
// - toggle latch flips on every core overflow or underflow
// - toggle latch clocks the auxiliary timer and drives an output pin
// - core overflow/underflow offered as count clock to the compare unit
// - core overflow/underflow may reload core timer from capture/reload
// - selected capture pin edge copies auxiliary count to capture/reload
// - auxiliary timer optionally cleared right after a capture
// - capture also triggered by neighbour count or direction transitions
package dtcr_pkg;

   //==========================================================
   // widths
   localparam int DW   = 16;
   localparam int AW   = 3;
   localparam int PS_W = 8;
   localparam int ST_W = 4;

   //==========================================================
   // register indices
   localparam logic [AW-1:0] REG_CORE_CTL = 3'h0;
   localparam logic [AW-1:0] REG_AUX_CTL  = 3'h1;
   localparam logic [AW-1:0] REG_CORE_CNT = 3'h2;
   localparam logic [AW-1:0] REG_AUX_CNT  = 3'h3;
   localparam logic [AW-1:0] REG_CAP_RLD  = 3'h4;
   localparam logic [AW-1:0] REG_STATUS   = 3'h5;
   localparam logic [AW-1:0] REG_MASK     = 3'h6;

   //==========================================================
   // control fields, both timers
   localparam int F_RUN    = 0;
   localparam int F_SRC    = 1;
   localparam int F_DIR    = 3;
   localparam int F_DIRPIN = 4;
   localparam int F_PS     = 5;
   // core timer only
   localparam int F_RELOAD = 8;
   localparam int F_TOUT   = 9;
   // auxiliary timer only
   localparam int F_CAPPIN = 8;
   localparam int F_CAPRISE = 9;
   localparam int F_CAPFALL = 10;
   localparam int F_CAPCLR = 11;
   localparam int F_CAPNBC = 12;
   localparam int F_CAPNBD = 13;

   //==========================================================
   // status bits
   localparam int ST_CORE_OVF = 0;
   localparam int ST_CORE_UNF = 1;
   localparam int ST_AUX_WRAP = 2;
   localparam int ST_CAPTURE  = 3;

   localparam logic [DW-1:0]   CNT_MAX  = 16'hFFFF;
   localparam logic [DW-1:0]   CNT_ZERO = 16'h0000;
   localparam logic [DW-1:0]   REG_RST  = 16'h0000;
   localparam logic [PS_W-1:0] PS_RST   = 8'h00;

   typedef enum logic [1:0] {
      SRC_PRESC = 2'b00,
      SRC_PIN   = 2'b01,
      SRC_LATCH = 2'b10,
      SRC_OFF   = 2'b11
   } src_t;

   // tick when the low sel+1 bits of the free prescaler are all ones;
   // sel 0 gives one tick every two clocks, the finest step
   function automatic logic presc_tick(input logic [PS_W-1:0] cnt,
                                       input logic [2:0]      sel);
      logic [PS_W:0] m;
      m = (9'h002 << sel) - 9'h001;
      return &(cnt | ~m[PS_W-1:0]);
   endfunction : presc_tick

endpackage : dtcr_pkg

// >>> src/dual_timer_capture_reload.sv
/*
 * Dual timer unit: core timer with toggle latch and reload, auxiliary
 * timer with capture into the capture/reload register, plus register
 * port, sticky status and interrupt. Assumes all pins are synchronous to
 * MCLK and that the register master never asserts both strobes together.
 */
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module dual_timer_capture_reload
   import dtcr_pkg::*;
(
   input  wire logic          MCLK,
   input  wire logic          RST,
   input  wire logic          CE,
   input  wire logic [AW-1:0] ADDR,
   input  wire logic [DW-1:0] WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output logic      [DW-1:0] RDATA,
   input  wire logic          CORE_COUNT_PIN,
   input  wire logic          AUX_COUNT_PIN,
   input  wire logic          CORE_DIRECTION_PIN,
   input  wire logic          AUX_DIRECTION_PIN,
   input  wire logic          CAPTURE_INPUT_PIN,
   input  wire logic          NEIGHBOR_COUNT_INPUT,
   input  wire logic          NEIGHBOR_DIRECTION_INPUT,
   output logic               TOGGLE_LATCH_PIN,
   output logic               COMPARE_CLK_OUT,
   output logic               IRQ
);

   typedef struct packed {
      logic [DW-1:0]   core_ctl;
      logic [DW-1:0]   aux_ctl;
      logic [DW-1:0]   cap_rld;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic [DW-1:0]   rdata;
      logic [PS_W-1:0] ps;
      logic            latch;
      logic            tpin;
      logic            cmp_clk;
      logic            irq;
      logic            core_pin_q;
      logic            aux_pin_q;
      logic            cap_q;
      logic            nbc_q;
      logic            nbd_q;
   } top_state_t;

   top_state_t r;
   top_state_t n;

   logic          core_tick;
   logic          aux_tick;
   logic          core_up;
   logic          aux_up;
   logic          core_load;
   logic [DW-1:0] core_load_val;
   logic          aux_load;
   logic          aux_clr;
   logic [DW-1:0] core_cnt;
   logic [DW-1:0] aux_cnt;
   logic          core_ovf;
   logic          core_unf;
   logic          core_wrap;
   logic          aux_ovf;
   logic          aux_unf;
   logic          cap_trig;
   logic          cap_edge;
   src_t          core_src;
   src_t          aux_src;
   logic [ST_W-1:0] st_evt;
   logic [ST_W-1:0] st_clr;

   assign RDATA            = r.rdata;
   assign TOGGLE_LATCH_PIN = r.tpin;
   assign COMPARE_CLK_OUT  = r.cmp_clk;
   assign IRQ              = r.irq;

   //==========================================================
   // count clock selection
   assign core_src  = src_t'(r.core_ctl[F_SRC +: 2]);
   assign aux_src   = src_t'(r.aux_ctl[F_SRC +: 2]);
   assign core_wrap = core_ovf | core_unf;

   always_comb
   begin
      core_tick = 1'b0;
      case (core_src)
         SRC_PRESC: core_tick = presc_tick(r.ps,
                                   r.core_ctl[F_PS +: 3]);
         SRC_PIN:   core_tick = CORE_COUNT_PIN & ~r.core_pin_q;
         default:   core_tick = 1'b0;
      endcase
      core_tick = core_tick & r.core_ctl[F_RUN];
   end

   always_comb
   begin
      aux_tick = 1'b0;
      case (aux_src)
         SRC_PRESC: aux_tick = presc_tick(r.ps,
                                  r.aux_ctl[F_PS +: 3]);
         SRC_PIN:   aux_tick = AUX_COUNT_PIN & ~r.aux_pin_q;
         // every latch change is one count: concatenated 32-bit chain
         SRC_LATCH: aux_tick = core_wrap;
         default:   aux_tick = 1'b0;
      endcase
      aux_tick = aux_tick & r.aux_ctl[F_RUN];
   end

   // pin level inverts the software direction while enabled
   assign core_up = r.core_ctl[F_DIR]
                    ^ (r.core_ctl[F_DIRPIN] & CORE_DIRECTION_PIN);
   assign aux_up  = r.aux_ctl[F_DIR]
                    ^ (r.aux_ctl[F_DIRPIN] & AUX_DIRECTION_PIN);

   //==========================================================
   // capture trigger
   assign cap_edge = (r.aux_ctl[F_CAPRISE] & CAPTURE_INPUT_PIN & ~r.cap_q)
                   | (r.aux_ctl[F_CAPFALL] & ~CAPTURE_INPUT_PIN & r.cap_q);
   assign cap_trig = (r.aux_ctl[F_CAPPIN] & cap_edge)
                   | (r.aux_ctl[F_CAPNBC]
                      & (NEIGHBOR_COUNT_INPUT ^ r.nbc_q))
                   | (r.aux_ctl[F_CAPNBD]
                      & (NEIGHBOR_DIRECTION_INPUT ^ r.nbd_q));

   //==========================================================
   // timer loads
   // software write wins over a reload in the same cycle
   assign core_load     = (WR && ADDR == REG_CORE_CNT)
                        | (r.core_ctl[F_RELOAD] & core_wrap);
   assign core_load_val = (WR && ADDR == REG_CORE_CNT) ? WDATA
                                                       : r.cap_rld;
   assign aux_load      = WR && ADDR == REG_AUX_CNT;
   // clear beats a same-cycle tick: that count is traded for exact intervals
   assign aux_clr       = cap_trig & r.aux_ctl[F_CAPCLR];

   updown_timer u_core_timer (
      .clk      (MCLK),
      .rst      (RST),
      .ce       (CE),
      .tick     (core_tick),
      .up       (core_up),
      .load     (core_load),
      .load_val (core_load_val),
      .clr      (1'b0),
      .cnt      (core_cnt),
      .wrap_up  (core_ovf),
      .wrap_dn  (core_unf)
   );

   updown_timer u_aux_timer (
      .clk      (MCLK),
      .rst      (RST),
      .ce       (CE),
      .tick     (aux_tick),
      .up       (aux_up),
      .load     (aux_load),
      .load_val (WDATA),
      .clr      (aux_clr),
      .cnt      (aux_cnt),
      .wrap_up  (aux_ovf),
      .wrap_dn  (aux_unf)
   );

   //==========================================================
   // status events
   always_comb
   begin
      st_evt              = '0;
      st_evt[ST_CORE_OVF] = core_ovf;
      st_evt[ST_CORE_UNF] = core_unf;
      st_evt[ST_AUX_WRAP] = aux_ovf | aux_unf;
      st_evt[ST_CAPTURE]  = cap_trig;
      st_clr              = '0;
      if (WR && ADDR == REG_STATUS)
      begin
         st_clr = WDATA[ST_W-1:0];
      end
   end

   //==========================================================
   // next state
   always_comb
   begin
      n            = r;
      n.ps         = r.ps + 8'h01;
      n.core_pin_q = CORE_COUNT_PIN;
      n.aux_pin_q  = AUX_COUNT_PIN;
      n.cap_q      = CAPTURE_INPUT_PIN;
      n.nbc_q      = NEIGHBOR_COUNT_INPUT;
      n.nbd_q      = NEIGHBOR_DIRECTION_INPUT;
      if (core_wrap)
      begin
         n.latch = ~r.latch;
      end
      n.cmp_clk = core_wrap;
      if (WR)
      begin
         if (ADDR == REG_CORE_CTL)
         begin
            n.core_ctl = WDATA;
         end
         else if (ADDR == REG_AUX_CTL)
         begin
            n.aux_ctl = WDATA;
         end
         else if (ADDR == REG_CAP_RLD)
         begin
            n.cap_rld = WDATA;
         end
         else if (ADDR == REG_MASK)
         begin
            n.mask = WDATA[ST_W-1:0];
         end
      end
      // a capture wins over a software write of the same cycle
      if (cap_trig)
      begin
         n.cap_rld = aux_cnt;
      end
      // set wins over the write-one clear
      n.status = (r.status & ~st_clr) | st_evt;
      n.irq    = |(n.status & n.mask);
      n.tpin   = n.latch & n.core_ctl[F_TOUT];
      if (RD)
      begin
         if (ADDR == REG_CORE_CTL)
         begin
            n.rdata = r.core_ctl;
         end
         else if (ADDR == REG_AUX_CTL)
         begin
            n.rdata = r.aux_ctl;
         end
         else if (ADDR == REG_CORE_CNT)
         begin
            n.rdata = core_cnt;
         end
         else if (ADDR == REG_AUX_CNT)
         begin
            n.rdata = aux_cnt;
         end
         else if (ADDR == REG_CAP_RLD)
         begin
            n.rdata = r.cap_rld;
         end
         else if (ADDR == REG_STATUS)
         begin
            n.rdata = {{(DW-ST_W){1'b0}}, r.status};
         end
         else if (ADDR == REG_MASK)
         begin
            n.rdata = {{(DW-ST_W){1'b0}}, r.mask};
         end
         else
         begin
            n.rdata = REG_RST;
         end
      end
      else
      begin
         n.rdata = REG_RST;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         r.core_ctl   <= REG_RST;
         r.aux_ctl    <= REG_RST;
         r.cap_rld    <= REG_RST;
         r.status     <= '0;
         r.mask       <= '0;
         r.rdata      <= REG_RST;
         r.ps         <= PS_RST;
         r.latch      <= 1'b0;
         r.tpin       <= 1'b0;
         r.cmp_clk    <= 1'b0;
         r.irq        <= 1'b0;
         r.core_pin_q <= 1'b0;
         r.aux_pin_q  <= 1'b0;
         r.cap_q      <= 1'b0;
         r.nbc_q      <= 1'b0;
         r.nbd_q      <= 1'b0;
      end
      else if (CE)
      begin
         r <= n;
      end
   end

   //==========================================================
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   presc_spacing_a: assert property (
      CE && core_src == SRC_PRESC && core_tick |=> !core_tick)
      else $error("prescaled tick closer than two clocks");
   latch_flip_a: assert property (
      CE && core_wrap |=> r.latch != $past(r.latch))
      else $error("toggle latch missed a core wrap");
   latch_pin_a: assert property (
      r.core_ctl[F_TOUT] |-> TOGGLE_LATCH_PIN == r.latch)
      else $error("toggle pin not following the latch");
   compare_clk_a: assert property (
      CE && core_wrap |=> COMPARE_CLK_OUT)
      else $error("compare clock pulse missing");
   core_reload_a: assert property (
      CE && core_wrap && r.core_ctl[F_RELOAD]
      && !(WR && ADDR == REG_CORE_CNT) |=> core_cnt == $past(r.cap_rld))
      else $error("core timer not reloaded");
   capture_val_a: assert property (
      CE && cap_trig |=> r.cap_rld == $past(aux_cnt))
      else $error("capture value wrong");
   capture_clear_a: assert property (
      CE && cap_trig && r.aux_ctl[F_CAPCLR] && !aux_load
      |=> aux_cnt == CNT_ZERO)
      else $error("aux timer not cleared after capture");
   neighbor_trig_a: assert property (
      r.aux_ctl[F_CAPNBC] && NEIGHBOR_COUNT_INPUT != r.nbc_q |-> cap_trig)
      else $error("neighbour count edge did not capture");
   irq_level_a: assert property (
      CE && |(r.status & r.mask) && !(WR && ADDR == REG_STATUS)
      && !(WR && ADDR == REG_MASK) |=> IRQ)
      else $error("interrupt not raised");
   core_step_a: assert property (
      CE && core_tick && core_up && !core_load
      |=> core_cnt == $past(core_cnt) + 16'h0001)
      else $error("core timer did not step up");
   aux_chain_a: assert property (
      CE && aux_src == SRC_LATCH && aux_tick && !aux_load && !aux_clr
      |=> aux_cnt != $past(aux_cnt))
      else $error("chained aux timer missed a wrap");

   reload_seen_c: cover property (CE && core_wrap && r.core_ctl[F_RELOAD]);
   capture_clr_c: cover property (CE && cap_trig && r.aux_ctl[F_CAPCLR]);
   chain_seen_c: cover property (CE && aux_src == SRC_LATCH && aux_tick);
   irq_seen_c: cover property (!IRQ ##1 IRQ);

endmodule : dual_timer_capture_reload

// >>> src/updown_timer.sv
/*
 * One 16-bit up/down counter with load and clear. Assumes tick, load and
 * clr are single-cycle qualifiers sampled on MCLK while ce is high.
 */
`timescale 1ns/1ps
module updown_timer
   import dtcr_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic          tick,
   input  wire logic          up,
   input  wire logic          load,
   input  wire logic [DW-1:0] load_val,
   input  wire logic          clr,
   output logic      [DW-1:0] cnt,
   output logic               wrap_up,
   output logic               wrap_dn
);

   typedef struct packed {
      logic [DW-1:0] cnt;
   } tmr_state_t;

   tmr_state_t r;
   tmr_state_t n;

   assign cnt     = r.cnt;
   // not gated by load so a reload may be started by the wrap itself
   assign wrap_up = ce & tick & up & (r.cnt == CNT_MAX);
   assign wrap_dn = ce & tick & ~up & (r.cnt == CNT_ZERO);

   always_comb
   begin
      n = r;
      if (load)
      begin
         n.cnt = load_val;
      end
      else if (clr)
      begin
         n.cnt = CNT_ZERO;
      end
      else if (tick)
      begin
         // natural 16-bit wrap in both directions
         n.cnt = up ? r.cnt + 16'h0001 : r.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r.cnt <= CNT_ZERO;
      end
      else if (ce)
      begin
         r <= n;
      end
   end

   //==========================================================
   // checks
   wrap_up_zero_a: assert property (@(posedge clk) disable iff (rst)
      wrap_up && !load && !clr |=> cnt == CNT_ZERO)
      else $error("up wrap did not reach zero");
   wrap_dn_max_a: assert property (@(posedge clk) disable iff (rst)
      wrap_dn && !load && !clr |=> cnt == CNT_MAX)
      else $error("down wrap did not reach maximum");

endmodule : updown_timer
